/* hdl/tcsp_serial_port.sv */
// Serial port with its bit-rate timer, and the transmit write FIFO.
// Assumes the core drives the register-file port on clk_sys and that the
// interrupt request register sits outside and takes one-cycle pulses.
`timescale 1ns/1ps

// ==========================================================
// FIFO
module tcsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic             clk_sys,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wptr;
    logic [AW-1:0]               rptr;
    logic [AW:0]                 count;
  } tcsp_fifo_state_t;

  tcsp_fifo_state_t st;
  tcsp_fifo_state_t next_st;
  logic             push;
  logic             pop;

  assign in_ready  = (st.count != (AW+1)'(DEPTH));
  assign out_valid = (st.count != '0);
  assign out_data  = st.mem[st.rptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wptr] = in_data;
      next_st.wptr         = st.wptr + AW'(1);
    end
    if (pop)
      next_st.rptr = st.rptr + AW'(1);
    next_st.count = st.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      st <= '0;
    else
      st <= next_st;
  end
endmodule : tcsp_fifo

// ==========================================================
// Serial port top
module tcsp_serial_port (
  // Clock and reset
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  // Register-file port
  input  wire tcsp_pkg::tcsp_reg_req_t reg_req,
  output logic [7:0]                  reg_rdata,
  output logic                        tx_write_ready,
  // Event requests
  output tcsp_pkg::tcsp_irq_t         irq_req,
  // Port 3 pins
  input  wire logic                   serial_in_pin,
  input  wire logic                   port3_out_bit7,
  output logic                        serial_out_pin,
  output logic                        serial_in_level
);
  import tcsp_pkg::*;

  typedef struct packed {
    logic [7:0]     port3_mode_reg;
    logic [7:0]     timer_mode_control;
    logic [7:0]     timer0_reload_count;
    logic [7:0]     timer0_prescale_setting;
    logic [1:0]     clk_div;
    logic [5:0]     pre_cnt;
    logic [7:0]     t0_cnt;
    logic           in_sync1;
    logic           in_sync2;
    logic           in_prev;
    tcsp_rx_state_t rx_state;
    logic [3:0]     rx_div;
    logic [3:0]     rx_bits;
    logic [7:0]     rx_shift;
    logic [7:0]     rx_buf;
    tcsp_tx_state_t tx_state;
    logic [3:0]     tx_div;
    logic [3:0]     tx_cnt;
    logic [10:0]    tx_frame;
    logic           pin_out;
    logic           in_level;
    logic [7:0]     rdata;
    logic           wr_ready;
    tcsp_irq_t      irq;
  } tcsp_state_t;

  tcsp_state_t st;
  tcsp_state_t next_st;
  logic        serial_en;
  logic        parity_en;
  logic        pre_tick;
  logic        t0_end;
  logic        rx_tick;
  logic        tx_tick;
  logic        buf_write;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic        fifo_pop;
  logic [7:0]  fifo_out_data;
  logic [7:0]  tx_byte;

  assign serial_en = st.port3_mode_reg[LP_P3M_SERIAL_BIT];
  assign parity_en = st.port3_mode_reg[LP_P3M_PARITY_BIT];
  assign buf_write = reg_req.wr && (reg_req.addr == LP_ADDR_SERIAL_DATA);
  // Writes wait here only while the port is disabled or the bit clock is stopped; once
  // both are on the transmitter takes each one at once, as an overwrite would
  assign fifo_pop  = fifo_out_valid && serial_en && st.timer_mode_control[LP_TMR_COUNT_BIT];

  tcsp_fifo #(
    .WIDTH (LP_FIFO_WIDTH),
    .DEPTH (LP_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_valid  (buf_write),
    .in_ready  (fifo_in_ready),
    .in_data   (reg_req.wdata),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  // ==========================================================
  // Bit-rate chain
  assign pre_tick = st.timer_mode_control[LP_TMR_COUNT_BIT] && (st.clk_div == LP_CLK_DIV_LAST);
  assign t0_end   = pre_tick && (st.pre_cnt == LP_PRE_ONE) && (st.t0_cnt == LP_T0_ONE);
  assign rx_tick  = serial_en && t0_end && (st.rx_state == TCSP_RX_SHIFT);
  assign tx_tick  = serial_en && t0_end && (st.tx_state == TCSP_TX_SEND);
  // Odd parity replaces bit 7 of the outgoing byte
  assign tx_byte  = parity_en ? {~^fifo_out_data[LP_DATA_MSB-1:0], fifo_out_data[LP_DATA_MSB-1:0]}
                              : fifo_out_data;

  always_comb
  begin
    next_st = st;
    next_st.irq = '0;
    next_st.clk_div = st.clk_div + 2'h1;

    // Register writes
    if (reg_req.wr)
    begin
      unique case (reg_req.addr)
        LP_ADDR_PORT3_MODE:  next_st.port3_mode_reg = reg_req.wdata;
        LP_ADDR_T0_RELOAD:   next_st.timer0_reload_count = reg_req.wdata;
        LP_ADDR_T0_PRESCALE: next_st.timer0_prescale_setting = reg_req.wdata;
        LP_ADDR_TIMER_MODE:  next_st.timer_mode_control = reg_req.wdata;
        default: ;
      endcase
    end

    // Prescaler and timer 0; a zero setting acts as a full count
    if (reg_req.wr && reg_req.addr == LP_ADDR_TIMER_MODE && reg_req.wdata[LP_TMR_LOAD_BIT])
    begin
      next_st.pre_cnt = st.timer0_prescale_setting[7:LP_PRE_VAL_LSB];
      next_st.t0_cnt  = st.timer0_reload_count;
      next_st.clk_div = '0;
    end
    else if (pre_tick)
    begin
      next_st.pre_cnt = st.pre_cnt - 6'h01;
      if (st.pre_cnt == LP_PRE_ONE)
      begin
        next_st.pre_cnt = st.timer0_prescale_setting[7:LP_PRE_VAL_LSB];
        next_st.t0_cnt  = st.t0_cnt - 8'h01;
        if (st.t0_cnt == LP_T0_ONE)
        begin
          next_st.t0_cnt = st.timer0_reload_count;
          // Single-pass mode stops counting after one end-of-count
          if (!st.timer0_prescale_setting[LP_PRE_CONT_BIT])
            next_st.timer_mode_control[LP_TMR_COUNT_BIT] = 1'b0;
        end
      end
    end
    next_st.irq.timer_req = t0_end && !serial_en;

    // ========================================================
    // Receiver; only the second synchroniser stage is looked at
    next_st.in_sync1 = serial_in_pin;
    next_st.in_sync2 = st.in_sync1;
    next_st.in_prev  = st.in_sync2;
    next_st.in_level = st.in_sync2;
    unique case (st.rx_state)
      TCSP_RX_HUNT:
        if (serial_en && st.in_prev && !st.in_sync2)
        begin
          next_st.rx_state = TCSP_RX_SHIFT;
          next_st.rx_div   = LP_ZERO4;
          next_st.rx_bits  = LP_ZERO4;
        end
      TCSP_RX_SHIFT:
        if (!serial_en)
        begin
          next_st.rx_state = TCSP_RX_HUNT;
          next_st.rx_shift = LP_ALL_ONES;
        end
        else if (rx_tick)
        begin
          next_st.rx_div = st.rx_div + LP_ONE4;
          // Sampling at count seven lands each bit at its centre
          if (st.rx_div == LP_RX_MID)
          begin
            next_st.rx_bits = st.rx_bits + LP_ONE4;
            if (st.rx_bits == LP_ZERO4)
            begin
              if (st.in_sync2)
                next_st.rx_state = TCSP_RX_HUNT;
            end
            else
            begin
              next_st.rx_shift = {st.in_sync2, st.rx_shift[7:1]};
              if (st.rx_bits == LP_RX_BITS)
              begin
                next_st.rx_buf = {st.in_sync2, st.rx_shift[7:1]};
                if (parity_en)
                  next_st.rx_buf[LP_DATA_MSB] = ~^{st.in_sync2, st.rx_shift[7:1]};
                next_st.irq.rx_req = 1'b1;
                next_st.rx_state   = TCSP_RX_HUNT;
                next_st.rx_shift   = LP_ALL_ONES;
              end
            end
          end
        end
    endcase

    // ========================================================
    // Transmitter
    if (fifo_pop)
    begin
      next_st.tx_state = TCSP_TX_SEND;
      next_st.tx_div   = LP_ZERO4;
      next_st.tx_cnt   = LP_ZERO4;
      next_st.tx_frame = {2'b11, tx_byte, 1'b0};
    end
    else if (!serial_en)
    begin
      next_st.tx_state = TCSP_TX_MARK;
      next_st.tx_frame = LP_TX_IDLE_FRAME;
    end
    else if (tx_tick)
    begin
      next_st.tx_div = st.tx_div + LP_ONE4;
      if (st.tx_div == LP_DIV_LAST)
      begin
        next_st.tx_frame = {1'b1, st.tx_frame[10:1]};
        next_st.tx_cnt   = st.tx_cnt + LP_ONE4;
        if (st.tx_cnt == LP_TX_LAST_BIT)
        begin
          next_st.tx_state   = TCSP_TX_MARK;
          next_st.tx_frame   = LP_TX_IDLE_FRAME;
          next_st.irq.tx_req = 1'b1;
        end
      end
    end
    next_st.pin_out = serial_en ? next_st.tx_frame[0] : port3_out_bit7;

    // Register reads; the serial address returns the receive side
    if (reg_req.rd)
    begin
      unique case (reg_req.addr)
        LP_ADDR_SERIAL_DATA: next_st.rdata = st.rx_buf;
        LP_ADDR_TIMER_MODE:  next_st.rdata = st.timer_mode_control;
        LP_ADDR_T0_RELOAD:   next_st.rdata = st.t0_cnt;
        LP_ADDR_PORT3_MODE:  next_st.rdata = st.port3_mode_reg;
        default:             next_st.rdata = LP_ALL_ONES;
      endcase
    end
    next_st.wr_ready = fifo_in_ready;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st          <= '0;
      st.rx_shift <= LP_ALL_ONES;
      st.tx_frame <= LP_TX_IDLE_FRAME;
      st.pin_out  <= 1'b1;
      st.in_sync1 <= 1'b1;
      st.in_sync2 <= 1'b1;
      st.in_prev  <= 1'b1;
      st.in_level <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign reg_rdata       = st.rdata;
  assign tx_write_ready  = st.wr_ready;
  assign irq_req         = st.irq;
  assign serial_out_pin  = st.pin_out;
  assign serial_in_level = st.in_level;

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_tx_mark_high: assert property (serial_en && st.tx_state == TCSP_TX_MARK && !fifo_pop |=> serial_out_pin)
    else $error("transmit output not high while idle");
  a_tx_write_start: assert property (fifo_pop |=> !serial_out_pin && st.tx_div == LP_ZERO4)
    else $error("write did not restart with a start bit");
  a_tx_done_req: assert property (irq_req.tx_req |-> serial_out_pin && $past(st.tx_cnt) == LP_TX_LAST_BIT)
    else $error("transmit request not after second stop bit");
  a_timer_req_gate: assert property (serial_en |=> !irq_req.timer_req)
    else $error("timer request raised while port enabled");
  a_rx_done_reset: assert property (irq_req.rx_req |-> st.rx_shift == LP_ALL_ONES && st.rx_state == TCSP_RX_HUNT)
    else $error("receiver not reset after character");
  a_rx_false_start: assert property (rx_tick && st.rx_div == LP_RX_MID && st.rx_bits == LP_ZERO4 && st.in_sync2
                                     |=> st.rx_state == TCSP_RX_HUNT)
    else $error("false start bit not rejected");
  a_rx_buf_hold: assert property (!next_st.irq.rx_req |=> $stable(st.rx_buf))
    else $error("receive buffer changed without a character");
  a_port_pin_pass: assert property (!serial_en && !$past(serial_en) |=> serial_out_pin == $past(port3_out_bit7))
    else $error("disabled port does not pass port bit");
  a_rx_parity_bit: assert property (irq_req.rx_req && $past(parity_en)
                                    |-> st.rx_buf[LP_DATA_MSB] == ~^{$past(st.in_sync2), $past(st.rx_shift[7:1])})
    else $error("parity error flag wrong");

  c_rx_char:     cover property (irq_req.rx_req);
  c_tx_char:     cover property (irq_req.tx_req);
  c_tx_abort:    cover property (fifo_pop && st.tx_state == TCSP_TX_SEND);
  c_fifo_full:   cover property (!tx_write_ready);
endmodule : tcsp_serial_port

/* common/tcsp_pkg.sv */
// Constants and carrier types for the timer-clocked asynchronous serial port.
// Assumes a byte-wide register-file port and a single system clock.
package tcsp_pkg;

  // ==========================================================
  // Register-file addresses
  localparam logic [7:0] LP_ADDR_SERIAL_DATA  = 8'hf0;
  localparam logic [7:0] LP_ADDR_TIMER_MODE   = 8'hf1;
  localparam logic [7:0] LP_ADDR_T0_RELOAD    = 8'hf4;
  localparam logic [7:0] LP_ADDR_T0_PRESCALE  = 8'hf5;
  localparam logic [7:0] LP_ADDR_PORT3_MODE   = 8'hf7;

  // ==========================================================
  // Field positions
  localparam int LP_TMR_LOAD_BIT   = 0;
  localparam int LP_TMR_COUNT_BIT  = 1;
  localparam int LP_PRE_CONT_BIT   = 0;
  localparam int LP_PRE_VAL_LSB    = 2;
  localparam int LP_P3M_SERIAL_BIT = 6;
  localparam int LP_P3M_PARITY_BIT = 7;
  localparam int LP_DATA_MSB       = 7;

  // ==========================================================
  // Reset values and counts
  localparam logic [7:0] LP_RESET_BYTE   = 8'h00;
  localparam logic [7:0] LP_ALL_ONES     = 8'hff;
  localparam logic [1:0] LP_CLK_DIV_LAST = 2'h3;
  localparam logic [5:0] LP_PRE_ONE      = 6'h01;
  localparam logic [7:0] LP_T0_ONE       = 8'h01;
  localparam logic [3:0] LP_RX_MID       = 4'h7;
  localparam logic [3:0] LP_DIV_LAST     = 4'hf;
  localparam logic [3:0] LP_RX_BITS      = 4'h8;
  localparam logic [3:0] LP_TX_LAST_BIT  = 4'ha;
  localparam logic [3:0] LP_ZERO4        = 4'h0;
  localparam logic [3:0] LP_ONE4         = 4'h1;
  localparam logic [10:0] LP_TX_IDLE_FRAME = 11'h7ff;
  localparam int LP_FIFO_WIDTH = 8;
  localparam int LP_FIFO_DEPTH = 8;

  typedef enum logic {TCSP_RX_HUNT, TCSP_RX_SHIFT} tcsp_rx_state_t;
  typedef enum logic {TCSP_TX_MARK, TCSP_TX_SEND} tcsp_tx_state_t;

  // Register-file access from the core
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tcsp_reg_req_t;

  // Event requests toward the interrupt request register
  typedef struct packed {
    logic rx_req;
    logic tx_req;
    logic timer_req;
  } tcsp_irq_t;

endpackage : tcsp_pkg

/* dv/tcsp_remote.sv */
// Remote serial station: sends frames on its line, captures frames it hears.
// Assumes the line idles high and one bit lasts BIT_CLKS system clocks.
`timescale 1ns/1ps

// ==========================================================
// Remote station
module tcsp_remote #(
  parameter int BIT_CLKS = 64
) (
  // Clock
  input  wire logic clk_sys,
  // Line
  input  wire logic line_in,
  output logic      line_out
);
  logic [9:0] rx_q[$];
  logic [9:0] sh;

  initial line_out = 1'b1;

  // Start bit, eight bits LSB first, two stop bits
  task automatic send_byte(input logic [7:0] b);
    logic [10:0] f;
    f = {2'b11, b, 1'b0};
    for (int i = 0; i < 11; i++)
    begin
      @(negedge clk_sys) line_out <= f[i];
      repeat (BIT_CLKS - 1) @(negedge clk_sys);
    end
  endtask : send_byte

  // Low pulse shorter than half a bit, a false start
  task automatic glitch(input int n);
    @(negedge clk_sys) line_out <= 1'b0;
    repeat (n) @(negedge clk_sys);
    line_out <= 1'b1;
  endtask : glitch

  // Samples mid-bit; keeps both stop levels so a short stop shows up
  always
  begin
    @(negedge line_in);
    repeat (BIT_CLKS / 2) @(negedge clk_sys);
    for (int i = 0; i < 10; i++)
    begin
      repeat (BIT_CLKS) @(negedge clk_sys);
      sh[i] = line_in;
    end
    rx_q.push_back(sh);
  end
endmodule : tcsp_remote

/* dv/tcsp_serial_port_test.sv */
// Self-checking bench for the serial port, with a remote station model.
// Assumes prescale 1 and timer 1, so one bit lasts 64 system clocks.
`timescale 1ns/1ps

// ==========================================================
// Bench top
module tcsp_serial_port_test;
  import tcsp_pkg::*;
  localparam int BIT = 64;
  logic          clk_sys;
  logic          rst;
  tcsp_reg_req_t req;
  logic [7:0]    rdata;
  logic          wr_rdy;
  logic          port_bit;
  logic          out_pin;
  logic          in_level;
  logic          line;
  tcsp_irq_t     irq;
  int            fail_count = 0;
  int            checks = 0;
  int            n_rx = 0;
  int            n_tx = 0;
  int            n_tm = 0;
  int            s;
  logic [9:0]    fr;

  initial clk_sys = 1'b0;
  always #2.5 clk_sys = ~clk_sys;

  tcsp_serial_port dut (
    .clk_sys         (clk_sys),
    .rst             (rst),
    .reg_req         (req),
    .reg_rdata       (rdata),
    .tx_write_ready  (wr_rdy),
    .irq_req         (irq),
    .serial_in_pin   (line),
    .port3_out_bit7  (port_bit),
    .serial_out_pin  (out_pin),
    .serial_in_level (in_level)
  );
  tcsp_remote #(
    .BIT_CLKS (BIT)
  ) rem (
    .clk_sys  (clk_sys),
    .line_in  (out_pin),
    .line_out (line)
  );

  // Requests are one-cycle pulses, so they are only counted here, never cleared;
  // sampled mid-cycle so each registered pulse is seen settled, once
  always @(negedge clk_sys)
  begin
    if (irq.rx_req === 1'b1) n_rx++;
    if (irq.tx_req === 1'b1) n_tx++;
    if (irq.timer_req === 1'b1) n_tm++;
  end

  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
    checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys);
    req.wr <= 1'b0;
  endtask : reg_wr

  // Read data is registered, so it is taken one cycle after the strobe
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys);
    req.rd <= 1'b0;
    @(negedge clk_sys);
    chk(nm, {2'b00, e}, {2'b00, rdata});
  endtask : rd_chk

  task automatic get_frame(input string nm, input logic [7:0] e);
    for (int k = 0; k < 1500 && rem.rx_q.size() == 0; k++) @(negedge clk_sys);
    fr = (rem.rx_q.size() > 0) ? rem.rx_q.pop_front() : 10'hxxx;
    chk(nm, {2'b11, e}, fr);
  endtask : get_frame

  task automatic final_report;
    if (fail_count == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : final_report

  // Whole run is near 8200 cycles; this leaves ample room
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    final_report();
  end

  // ==========================================================
  // Tests
  initial
  begin
    rst = 1'b1;
    req = '0;
    port_bit = 1'b1;
    repeat (12) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys) port_bit = 1'b0;
    repeat (3) @(negedge clk_sys);
    chk("out_port", 10'h0, {9'h0, out_pin});
    port_bit = 1'b1;
    rd_chk("p3m_reset", LP_ADDR_PORT3_MODE, 8'h00);
    rd_chk("pre_read", LP_ADDR_T0_PRESCALE, 8'hff);
    rd_chk("unmapped", 8'h20, 8'hff);
    reg_wr(LP_ADDR_T0_PRESCALE, 8'h05);
    reg_wr(LP_ADDR_T0_RELOAD, 8'h01);
    reg_wr(LP_ADDR_TIMER_MODE, 8'h03);
    rd_chk("tmr", LP_ADDR_TIMER_MODE, 8'h03);
    repeat (20) @(negedge clk_sys);
    chk("timer_req", 10'h1, {9'h0, n_tm > 0});
    for (int i = 0; i < 8; i++) reg_wr(LP_ADDR_SERIAL_DATA, 8'h10 + 8'(i));
    @(negedge clk_sys);
    chk("fifo_full", 10'h0, {9'h0, wr_rdy});
    reg_wr(LP_ADDR_SERIAL_DATA, 8'h99);
    repeat (700) @(negedge clk_sys);
    rem.rx_q.delete();
    // Queued writes pop back to back, each aborting the last
    reg_wr(LP_ADDR_PORT3_MODE, 8'h40);
    // A timer pulse launched at the enable edge is counted one half cycle later
    @(negedge clk_sys) s = n_tm;
    get_frame("tx_last", 8'h17);
    repeat (BIT) @(negedge clk_sys);
    chk("tx_req", 10'h1, 10'(n_tx));
    chk("timer_off", 10'(s), 10'(n_tm));
    chk("tx_idle", 10'h1, {9'h0, out_pin});
    rd_chk("p3m", LP_ADDR_PORT3_MODE, 8'h40);
    reg_wr(LP_ADDR_PORT3_MODE, 8'hc0);
    reg_wr(LP_ADDR_SERIAL_DATA, 8'h03);
    get_frame("tx_par1", 8'h83);
    reg_wr(LP_ADDR_SERIAL_DATA, 8'h07);
    get_frame("tx_par0", 8'h07);
    rem.send_byte(8'h83);
    rd_chk("rx_par_ok", LP_ADDR_SERIAL_DATA, 8'h03);
    rem.send_byte(8'h03);
    rd_chk("rx_par_err", LP_ADDR_SERIAL_DATA, 8'h83);
    reg_wr(LP_ADDR_PORT3_MODE, 8'h40);
    s = n_rx;
    rem.send_byte(8'h3c);
    rd_chk("rx_byte", LP_ADDR_SERIAL_DATA, 8'h3c);
    chk("rx_req", 10'(s + 1), 10'(n_rx));
    fork
      rem.glitch(20);
      begin
        repeat (7) @(negedge clk_sys);
        chk("in_level", 10'h0, {9'h0, in_level});
      end
    join
    repeat (BIT) @(negedge clk_sys);
    chk("false_start", 10'(s + 1), 10'(n_rx));
    rem.send_byte(8'h5a);
    rd_chk("after_false", LP_ADDR_SERIAL_DATA, 8'h5a);
    rem.send_byte(8'h11);
    rem.send_byte(8'h22);
    rd_chk("overwrite", LP_ADDR_SERIAL_DATA, 8'h22);
    chk("rx_count", 10'(s + 4), 10'(n_rx));
    // Break: a null write mid-frame restarts at once, aligned to the write
    s = n_tx;
    reg_wr(LP_ADDR_SERIAL_DATA, 8'hff);
    repeat (3 * BIT) @(negedge clk_sys);
    reg_wr(LP_ADDR_SERIAL_DATA, 8'h00);
    repeat (2) @(negedge clk_sys);
    chk("brk_start", 10'h0, {9'h0, out_pin});
    repeat (9 * BIT - 10) @(negedge clk_sys);
    chk("brk_low", 10'h0, {9'h0, out_pin});
    repeat (16) @(negedge clk_sys);
    chk("brk_stop", 10'h1, {9'h0, out_pin});
    repeat (3 * BIT) @(negedge clk_sys);
    chk("brk_req", 10'(s + 1), 10'(n_tx));
    final_report();
  end
endmodule : tcsp_serial_port_test
